// ### hdl/adc_sweep_defs.vh
/*
 Constants for the delayed-trigger sweep controller: register offsets, field positions,
 reset values and conversion cycle counts.
 Assumes inclusion by bare name from the design files under hdl/.
*/
`ifndef ADC_SWEEP_DEFS_VH
`define ADC_SWEEP_DEFS_VH

`define OFF_CONTROL_A 8'h00
`define OFF_CONTROL_B 8'h04
`define OFF_CONTROL_C 8'h08
`define OFF_TRIG_SEL 8'h0C
`define OFF_STATUS 8'h10
`define OFF_RESULT0 8'h20
`define OFF_RESULT_LAST 8'h3C

`define CA_GO_BIT 0
`define CB_WIDTH_LO 0
`define CB_WIDTH_HI 1
`define CB_RES_BIT 3
`define CB_LADDER_BIT 5
`define CC_SH_BIT 0
`define CC_GROUP_LO 1
`define CC_GROUP_HI 2
`define TS_TRIG_EN_BIT 0
`define TS_SRC_BIT 1
`define TS_TIMER_A_BIT 2
`define TS_TIMER_B_BIT 3

`define RST_CONTROL_A 8'h00
`define RST_CONTROL_B 8'h00
`define RST_CONTROL_C 8'h00
`define RST_TRIG_SEL 8'h00

`define CONV_CYCLES_8 28
`define CONV_CYCLES_10 33
`define CONV_CYCLES_NOSH 49

`endif

// ### hdl/conv_timer.v
/*
 Per-channel conversion timer: counts the cycles of one conversion and pulses done.
 Assumes a start pulse from the sequencer on the same clock.
*/
`default_nettype none
`include "adc_sweep_defs.vh"

module conv_timer #(
   parameter CW = 6
) (
   input wire ref_clk,
   input wire reset,
   input wire start,
   input wire abort,
   input wire [CW-1:0] cycles,
   output reg busy,
   output reg done
);
   reg [CW-1:0] count_r;

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         count_r <= {CW{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
         end else if (start) begin
            busy <= 1'b1;
            // Loading two below the count makes start-to-start equal to cycles, since the
            // sequencer starts the next channel on the edge that sees done.
            count_r <= cycles - {{(CW-2){1'b0}}, 2'b10};
         end else if (busy) begin
            if (count_r == {CW{1'b0}}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // conv_timer

`default_nettype wire

// ### hdl/adc_delayed_edge_sweep_ctrl.v
/*
 Sequencer for the two-edge delayed-trigger sweep of a successive-approximation converter,
 with an AXI4-Lite register slave. The analog core is outside: it receives a sample strobe
 and channel number and delivers its code on convCode, valid when the timer finishes.
 Assumes ref_clk is the converter clock and extTrigger is an asynchronous pin.
 Edges that arrive while later channels convert are dropped, not queued.
*/
// Summary of operation
// - First trigger falling edge converts channel zero.
// - Later channels wait for second falling edge.
// - Early second edge samples now, converts later.
// - Edges ignored while later channels convert.
// - Edge after completion starts a new sweep.
// - Sweep ends on completion or go-bit clear.
// - Interrupt request pulses when sweep completes.
// - Width field picks 2/4/6/8 channels.
// - All sweep channels come from one group.
// - Each result lands in its own register.
// - Edges sampled on clock; spacing at least one.
// - Resolution bit picks 10-bit or 8-bit storage.
// - Sample-hold: 28 or 33 cycles per channel.
// - Ladder disconnected while its bit is zero.
`default_nettype none
`include "adc_sweep_defs.vh"

module adc_delayed_edge_sweep_ctrl #(
   parameter NCH = 8
) (
   input wire ref_clk,
   input wire reset,
   input wire extTrigger,
   input wire [9:0] convCode,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg sampleStrobe,
   output reg [2:0] sampleChannel,
   output reg [1:0] inputGroup,
   output reg ladderConnect,
   output reg convIrq
);
   localparam ST_IDLE = 3'd0;
   localparam ST_CONV0 = 3'd1;
   localparam ST_WAIT2 = 3'd2;
   localparam ST_SAMPLE = 3'd3;
   localparam ST_CONVN = 3'd4;

   reg [7:0] controlA_r;
   reg [7:0] controlB_r;
   reg [7:0] controlC_r;
   reg [7:0] trigSel_r;
   reg [9:0] result_r [0:NCH-1];
   reg [2:0] state_r;
   reg [2:0] chan_r;
   reg early2_r;
   reg sweepDone_r;
   reg trigSync1_r, trigSync2_r, trigPrev_r;
   reg [7:0] awAddr_r;
   reg awHeld_r;
   reg [31:0] wData_r;
   reg [3:0] wStrb_r;
   reg wHeld_r;
   reg goClearSeen_r;
   reg [1:0] groupLatch_r;
   reg resLatch_r;

   wire trigFall = trigPrev_r & ~trigSync2_r;
   wire goBit = controlA_r[`CA_GO_BIT];
   wire modeSel = ~trigSel_r[`TS_TRIG_EN_BIT] & trigSel_r[`TS_SRC_BIT] &
      ~trigSel_r[`TS_TIMER_A_BIT] & ~trigSel_r[`TS_TIMER_B_BIT];
   wire [1:0] widthField = controlB_r[`CB_WIDTH_HI:`CB_WIDTH_LO];
   wire [2:0] lastChan = {widthField, 1'b1};
   wire [5:0] convCycles = ~controlC_r[`CC_SH_BIT] ? 6'd`CONV_CYCLES_NOSH :
      controlB_r[`CB_RES_BIT] ? 6'd`CONV_CYCLES_10 : 6'd`CONV_CYCLES_8;
   wire timerBusy, timerDone;
   reg timerStart;
   wire halt = (state_r != ST_IDLE) && goClearSeen_r;
   // Software may not set the go bit in this mode, so hardware raises it at the first
   // edge and drops it at completion; only then can a software clear act as a halt.
   wire sweepStart = !halt && modeSel && (state_r == ST_IDLE) && trigFall;
   wire sweepEnd = !halt && modeSel && (state_r == ST_CONVN) && timerDone && (chan_r == lastChan);

   conv_timer #(.CW(6)) u_timer (
      .ref_clk(ref_clk),
      .reset(reset),
      .start(timerStart),
      .abort(halt),
      .cycles(convCycles),
      .busy(timerBusy),
      .done(timerDone)
   );

   // The pin is asynchronous, so it passes two flip-flops before edge detection.
   // The chain resets high, the pin's idle level, so no false edge follows reset.
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         trigSync1_r <= 1'b1;
         trigSync2_r <= 1'b1;
         trigPrev_r <= 1'b1;
      end else begin
         trigSync1_r <= extTrigger;
         trigSync2_r <= trigSync1_r;
         trigPrev_r <= trigSync2_r;
      end
   end

   // An early second edge only samples channel one; its conversion starts in the sample state once
   // channel zero is done, so the converter never runs two channels at once.
   always @* begin
      timerStart = 1'b0;
      if (!halt && modeSel) begin
         case (state_r)
            ST_IDLE: timerStart = trigFall;
            ST_WAIT2: timerStart = trigFall;
            ST_SAMPLE: timerStart = 1'b1;
            ST_CONVN: timerStart = timerDone && (chan_r != lastChan);
            default: timerStart = 1'b0;
         endcase
      end
   end

   // Sequencer. Only edges in idle, during channel zero and in the wait for the second edge are acted upon.
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         chan_r <= 3'd0;
         early2_r <= 1'b0;
         sweepDone_r <= 1'b0;
         sampleStrobe <= 1'b0;
         sampleChannel <= 3'd0;
         groupLatch_r <= 2'd0;
         resLatch_r <= 1'b0;
         convIrq <= 1'b0;
      end else begin
         sampleStrobe <= 1'b0;
         sweepDone_r <= 1'b0;
         convIrq <= 1'b0;
         if (halt || !modeSel) begin
            state_r <= ST_IDLE;
            early2_r <= 1'b0;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  if (trigFall) begin
                     state_r <= ST_CONV0;
                     chan_r <= 3'd0;
                     sampleStrobe <= 1'b1;
                     sampleChannel <= 3'd0;
                     groupLatch_r <= controlC_r[`CC_GROUP_HI:`CC_GROUP_LO];
                     resLatch_r <= controlB_r[`CB_RES_BIT];
                     early2_r <= 1'b0;
                  end
               end
               ST_CONV0: begin
                  if (trigFall && !early2_r) begin
                     early2_r <= 1'b1;
                     sampleStrobe <= 1'b1;
                     sampleChannel <= 3'd1;
                  end
                  if (timerDone) begin
                     chan_r <= 3'd1;
                     state_r <= (early2_r || trigFall) ? ST_SAMPLE : ST_WAIT2;
                  end
               end
               ST_WAIT2: begin
                  if (trigFall) begin
                     state_r <= ST_CONVN;
                     sampleStrobe <= 1'b1;
                     sampleChannel <= 3'd1;
                  end
               end
               ST_SAMPLE: begin
                  state_r <= ST_CONVN;
                  early2_r <= 1'b0;
               end
               ST_CONVN: begin
                  // Further edges here are ignored on purpose.
                  if (timerDone) begin
                     if (chan_r == lastChan) begin
                        state_r <= ST_IDLE;
                        sweepDone_r <= 1'b1;
                        convIrq <= 1'b1;
                     end else begin
                        chan_r <= chan_r + 3'd1;
                        sampleStrobe <= 1'b1;
                        sampleChannel <= chan_r + 3'd1;
                     end
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Results are written per channel as each conversion ends.
   // A halted conversion leaves the previous result in place.
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1) begin : g_res
         always @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               result_r[gi] <= 10'h000;
            end else if (timerDone && !halt && {29'd0, chan_r} == gi) begin
               result_r[gi] <= resLatch_r ? convCode : {2'b00, convCode[9:2]};
            end
         end
      end
   endgenerate

   // The group is frozen for the whole sweep so that every channel comes from one group.
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         inputGroup <= 2'd0;
         ladderConnect <= 1'b0;
      end else begin
         inputGroup <= (state_r == ST_IDLE) ? controlC_r[`CC_GROUP_HI:`CC_GROUP_LO] : groupLatch_r;
         ladderConnect <= controlB_r[`CB_LADDER_BIT];
      end
   end

   // Write channel: address and data are held in either order; response follows both.
   // A halt is recognised only as a write that clears a set go bit; a write with the go
   // bit at zero outside a sweep leaves the sequencer alone.
   wire wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h00000000;
         wStrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         controlA_r <= `RST_CONTROL_A;
         controlB_r <= `RST_CONTROL_B;
         controlC_r <= `RST_CONTROL_C;
         trigSel_r <= `RST_TRIG_SEL;
         goClearSeen_r <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
         goClearSeen_r <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wrFire) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            if (wStrb_r[0]) begin
               case (awAddr_r & 8'hFC)
                  `OFF_CONTROL_A: begin
                     controlA_r <= wData_r[7:0];
                     goClearSeen_r <= goBit && !wData_r[`CA_GO_BIT];
                  end
                  `OFF_CONTROL_B: controlB_r <= wData_r[7:0];
                  `OFF_CONTROL_C: controlC_r <= wData_r[7:0];
                  `OFF_TRIG_SEL: trigSel_r <= wData_r[7:0];
                  `OFF_STATUS: s_axi_bresp <= 2'b00;
                  default: s_axi_bresp <= 2'b10;
               endcase
            end
         end
         // A hardware set wins over a software clear in the same cycle.
         if (sweepStart) begin
            controlA_r[`CA_GO_BIT] <= 1'b1;
         end else if (sweepEnd) begin
            controlA_r[`CA_GO_BIT] <= 1'b0;
         end
      end
   end

   // Read channel: one cycle from address acceptance to data.
   wire [7:0] ra = s_axi_araddr & 8'hFC;
   // Status: state, timer busy, completion pulse and the early-second-edge flag.
   wire [7:0] statusWord = {2'b00, early2_r, sweepDone_r, timerBusy, state_r};
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            if (ra >= `OFF_RESULT0 && ra <= `OFF_RESULT_LAST) begin
               s_axi_rdata <= {22'h000000, result_r[ra[4:2]]};
            end else begin
               case (ra)
                  `OFF_CONTROL_A: s_axi_rdata <= {24'h000000, controlA_r};
                  `OFF_CONTROL_B: s_axi_rdata <= {24'h000000, controlB_r};
                  `OFF_CONTROL_C: s_axi_rdata <= {24'h000000, controlC_r};
                  `OFF_TRIG_SEL: s_axi_rdata <= {24'h000000, trigSel_r};
                  `OFF_STATUS: s_axi_rdata <= {24'h000000, statusWord};
                  default: begin
                     s_axi_rdata <= 32'h00000000;
                     s_axi_rresp <= 2'b10;
                  end
               endcase
            end
         end
      end
   end
endmodule // adc_delayed_edge_sweep_ctrl

`default_nettype wire

// ### dv/trig_source.sv
/* Trigger source model: makes one falling edge on the trigger pin per request.
 Assumes fire is a one-cycle request from the bench on ref_clk. */
`default_nettype none
module trig_source (
   input wire logic ref_clk,
   input wire logic fire,
   output logic extTrigger
);
   timeunit 1ns;
   timeprecision 1ps;
   int lowCnt = 0;
   initial extTrigger = 1'b1;
   // The pin idles high; each edge is held low for four clocks, well above the sampling period.
   always @(posedge ref_clk) begin
      if (fire) begin
         lowCnt <= 4;
         extTrigger <= 1'b0;
      end else if (lowCnt > 1) begin
         lowCnt <= lowCnt - 1;
      end else begin
         lowCnt <= 0;
         extTrigger <= 1'b1;
      end
   end
endmodule // trig_source
`default_nettype wire

// ### dv/adc_sweep_props.sv
/* Checker for the sweep controller ports.
 Assumes it is bound to the top module and sees only its ports. */
`default_nettype none
module adc_sweep_props (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sampleStrobe,
   input wire logic [2:0] sampleChannel,
   input wire logic [1:0] inputGroup,
   input wire logic ladderConnect,
   input wire logic convIrq,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [8:0] gap_r;
   logic [2:0] lastChan_r;
   logic [1:0] group_r;
   logic later_r;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gap_r <= 9'h000;
         lastChan_r <= 3'h0;
         group_r <= 2'h0;
         later_r <= 1'b0;
      end else begin
         gap_r <= sampleStrobe ? 9'h000 : (gap_r == 9'h1FF ? gap_r : gap_r + 9'h001);
         if (sampleStrobe) lastChan_r <= sampleChannel;
         if (sampleStrobe && sampleChannel == 3'h0) group_r <= inputGroup;
         // A write may be a halt, after which a new first edge is legal.
         if (convIrq || (s_axi_wvalid && s_axi_wready)) later_r <= 1'b0;
         else if (sampleStrobe && sampleChannel == 3'h1) later_r <= 1'b1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence bHeld;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence rHeld;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   irq_one_cycle_a: assert property (convIrq |=> !convIrq) else $error("irq too long");
   strobe_pulse_a: assert property (sampleStrobe |=> !sampleStrobe) else $error("strobe too long");
   chan_gap_a: assert property (sampleStrobe && sampleChannel > 3'h1 |-> gap_r >= 9'd27)
      else $error("conversion too short");
   // From channel three on, the previous strobe started its timer, so the spacing is exact.
   chan_period_a: assert property (sampleStrobe && sampleChannel > 3'h2 |->
      gap_r == 9'd27 || gap_r == 9'd32 || gap_r == 9'd48) else $error("conversion period wrong");
   irq_gap_a: assert property (convIrq |-> gap_r >= 9'd27) else $error("irq before conversion end");
   chan_order_a: assert property (sampleStrobe && sampleChannel > 3'h1 |-> sampleChannel == lastChan_r + 3'h1)
      else $error("channel order");
   group_hold_a: assert property (sampleStrobe && sampleChannel != 3'h0 |-> inputGroup == group_r)
      else $error("group changed in sweep");
   no_restart_a: assert property (later_r |-> !(sampleStrobe && sampleChannel == 3'h0))
      else $error("restart during sweep");
   bresp_hold_a: assert property (bHeld |=> s_axi_bvalid) else $error("bvalid dropped");
   rresp_hold_a: assert property (rHeld |=> s_axi_rvalid) else $error("rvalid dropped");
   ladder_write_a: assert property ($changed(ladderConnect) |->
      $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4)) else $error("ladder moved");
endmodule // adc_sweep_props
bind adc_delayed_edge_sweep_ctrl adc_sweep_props props_u (.ref_clk(ref_clk), .reset(reset),
   .sampleStrobe(sampleStrobe), .sampleChannel(sampleChannel), .inputGroup(inputGroup),
   .ladderConnect(ladderConnect), .convIrq(convIrq), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ### dv/tb.sv
/* Self-checking bench for the delayed-trigger sweep controller.
 Assumes the design under hdl/ and the trigger source model. */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset, fire, awvalid, wvalid, bready, arvalid, rready;
   logic [9:0] convCode;
   logic [7:0] awaddr, araddr, chanMask;
   logic [31:0] wdata;
   logic [1:0] seenGroup;
   logic [1:0] wResp;
   wire logic extTrigger, awready, wready, bvalid, arready, rvalid, sampleStrobe, ladderConnect, convIrq;
   wire logic [1:0] bresp, rresp, inputGroup;
   wire logic [31:0] rdata;
   wire logic [2:0] sampleChannel;
   int num_errors = 0, num_checks = 0, strobes = 0, irqs = 0;
   adc_delayed_edge_sweep_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .extTrigger(extTrigger),
      .convCode(convCode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sampleStrobe(sampleStrobe),
      .sampleChannel(sampleChannel), .inputGroup(inputGroup), .ladderConnect(ladderConnect), .convIrq(convIrq));
   trig_source trig_u (.ref_clk(ref_clk), .fire(fire), .extTrigger(extTrigger));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (sampleStrobe === 1'b1) begin
         strobes <= strobes + 1;
         chanMask[sampleChannel] <= 1'b1;
         seenGroup <= inputGroup;
      end
      if (convIrq === 1'b1) irqs <= irqs + 1;
   end
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stall(input string what);
      check(what, 32'h0, 32'h1);
      report_and_stop();
   endtask
   task automatic waitUntil(input bit onIrq, input int n, input int lim);
      for (int i = 0; i < lim && (onIrq ? irqs : strobes) < n; i++) @(posedge ref_clk);
      if ((onIrq ? irqs : strobes) < n) stall("wait timeout");
   endtask
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            wResp = bresp;
            break;
         end
      end
      bready <= 1'b0;
      if (n == 50) stall("write timeout");
      @(posedge ref_clk);
   endtask
   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 50) stall("read timeout");
      @(posedge ref_clk);
   endtask
   task automatic pulse;
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic test_reset;
      logic [31:0] d;
      logic [1:0] r;
      check("ladder idle", {31'h0, ladderConnect}, 32'h0);
      axiRead(8'h04, d, r);
      check("control b", d, 32'h0);
      axiRead(8'h0C, d, r);
      check("trigger select", d, 32'h0);
      axiRead(8'h40, d, r);
      check("unmapped resp", {30'h0, r}, 32'h2);
      check("unmapped data", d, 32'h0);
      axiWrite(8'h40, 32'h0);
      check("unmapped write", {30'h0, wResp}, 32'h2);
      pulse();
      repeat (8) @(posedge ref_clk);
      check("mode off", 32'(strobes), 32'h0);
      $display("test_reset done");
   endtask
   task automatic test_setup;
      axiWrite(8'h0C, 32'h2);
      axiWrite(8'h08, 32'h1);
      axiWrite(8'h04, 32'h20);
      check("write resp", {30'h0, wResp}, 32'h0);
      repeat (4) @(posedge ref_clk);
      check("ladder on", {31'h0, ladderConnect}, 32'h1);
      $display("test_setup done");
   endtask
   task automatic test_widths;
      int n, s0, i0;
      logic [9:0] code;
      logic [31:0] d;
      logic [1:0] r;
      for (int w = 0; w < 4; w++) begin
         n = 2 * (w + 1);
         code = 10'h2B7 ^ 10'(w);
         convCode <= code;
         chanMask <= 8'h00;
         axiWrite(8'h08, 32'h1 | 32'(w[0]) << 1);
         axiWrite(8'h04, 32'h20 | 32'(w[0]) << 3 | 32'(w));
         s0 = strobes;
         i0 = irqs;
         pulse();
         waitUntil(0, s0 + 1, 40);
         repeat (60) @(posedge ref_clk);
         check("held after first", 32'(strobes - s0), 32'h1);
         pulse();
         waitUntil(0, s0 + 2, 40);
         repeat (5) @(posedge ref_clk);
         pulse();
         waitUntil(1, i0 + 1, n * 40 + 40);
         repeat (5) @(posedge ref_clk);
         check("strobe count", 32'(strobes - s0), 32'(n));
         check("channel set", {24'h0, chanMask}, 32'((1 << n) - 1));
         check("group", {30'h0, seenGroup}, 32'(w[0]));
         for (int c = 0; c < n; c++) begin
            axiRead(8'h20 + 8'(4 * c), d, r);
            check("result", d, w[0] ? 32'(code) : 32'(code[9:2]));
         end
      end
      $display("test_widths done");
   endtask
   task automatic test_early;
      int s0, i0;
      logic [31:0] d;
      logic [1:0] r;
      convCode <= 10'h1C6;
      axiWrite(8'h04, 32'h20);
      s0 = strobes;
      i0 = irqs;
      pulse();
      waitUntil(0, s0 + 1, 40);
      repeat (5) @(posedge ref_clk);
      pulse();
      waitUntil(0, s0 + 2, 12);
      waitUntil(1, i0 + 1, 150);
      repeat (5) @(posedge ref_clk);
      check("irq count", 32'(irqs - i0), 32'h1);
      axiRead(8'h20, d, r);
      check("early ch0", d, 32'h71);
      axiRead(8'h24, d, r);
      check("early ch1", d, 32'h71);
      $display("test_early done");
   endtask
   task automatic test_halt;
      int s0, i0;
      logic [31:0] d;
      logic [1:0] r;
      axiWrite(8'h04, 32'h23);
      s0 = strobes;
      i0 = irqs;
      pulse();
      waitUntil(0, s0 + 1, 40);
      axiRead(8'h00, d, r);
      check("go set", d, 32'h1);
      repeat (40) @(posedge ref_clk);
      pulse();
      waitUntil(0, s0 + 2, 40);
      axiWrite(8'h00, 32'h0);
      repeat (300) @(posedge ref_clk);
      check("halt irq", 32'(irqs - i0), 32'h0);
      check("halt strobes", 32'(strobes - s0), 32'h2);
      axiRead(8'h10, d, r);
      check("halt status", d, 32'h0);
      chanMask <= 8'h00;
      pulse();
      waitUntil(0, s0 + 3, 40);
      check("restart ch0", {24'h0, chanMask}, 32'h1);
      repeat (40) @(posedge ref_clk);
      pulse();
      waitUntil(1, i0 + 1, 400);
      axiRead(8'h00, d, r);
      check("go cleared", d, 32'h0);
      $display("test_halt done");
   endtask
   initial begin
      {reset, fire, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
      {convCode, awaddr, araddr, wdata, chanMask, seenGroup} = 68'h0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      test_reset();
      test_setup();
      test_widths();
      test_early();
      test_halt();
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
